// *** hw/lpm_defs.svh ***
// Purpose: constants for the far-end line and pointer justification counters
// Assumes: 125 MHz clock, one STS-1 path, 32-bit register port
// Notes: offsets are byte addresses on the plain register port
//
// Functional notes
// - count detected positive justifications per path
// - count detected negative justifications per path
// - count generated positive justifications per path
// - count generated negative justifications per path
// - justification counts hidden unless monitoring enabled
// - add reported far-end errors each frame
// - clamp report: 8xN below OC-48, 255 else
// - errored second: any error or RDI-L
// - severe second: errors reach K or RDI-L
// - ten severe seconds declare unavailable; count seconds
// - ten non-severe seconds clear unavailability
// - count failure events from RFI-L declaration
// - boundary-spanning failure counted in starting period
`ifndef LPM_DEFS_SVH
`define LPM_DEFS_SVH

`define LPM_A_CTRL 8'h00
`define LPM_A_K 8'h04
`define LPM_A_STAT 8'h08
`define LPM_A_MASK 8'h0C
`define LPM_A_CNT0 8'h10
`define LPM_A_LIVE 8'h34

`define LPM_CTRL_PJ_EN 0
`define LPM_CTRL_OC48 1
`define LPM_CTRL_CLR 2

`define LPM_EV_SEC 0
`define LPM_EV_SES 1
`define LPM_EV_AVAIL 2
`define LPM_EV_FAIL 3
`define LPM_N_EV 4

`define LPM_CNT_PD 0
`define LPM_CNT_ND 1
`define LPM_CNT_PG 2
`define LPM_CNT_NG 3
`define LPM_CNT_CV 4
`define LPM_CNT_ES 5
`define LPM_CNT_SES 6
`define LPM_CNT_UAS 7
`define LPM_CNT_FC 8
`define LPM_N_CNT 9
`define LPM_N_PJ 4

`define LPM_K_RST 16'h0010
`define LPM_STS_N 8'h01
`define LPM_REI_MAX_LOW (8'h08 * `LPM_STS_N)
`define LPM_REI_MAX_OC48 8'hFF
`define LPM_UNAV_RUN 4'hA

`define LPM_SEC_NS 1000000000
`define LPM_CLK_NS 8
`define LPM_SEC_CYCLES (`LPM_SEC_NS / `LPM_CLK_NS)

`endif

// *** hw/lpm_pkg.sv ***
// Purpose: types for the far-end line and pointer justification counters
// Assumes: constants come from lpm_defs.svh
// Notes: the whole block state is one packed struct
`include "lpm_defs.svh"

package lpm_pkg;

    typedef enum logic {
        LPM_AVAIL,
        LPM_UNAVAIL
    } lpm_avail_t;

    typedef struct packed {
        logic [`LPM_N_CNT-1:0][31:0] cnt;
        logic [31:0] cv_cur;
        logic rdi_seen;
        logic rfi_d;
        logic [26:0] sec_cnt;
        logic [3:0] run;
        lpm_avail_t avail;
        logic pj_en;
        logic oc48;
        logic [15:0] k;
        logic [`LPM_N_EV-1:0] stat;
        logic [`LPM_N_EV-1:0] mask;
        logic [31:0] rdata;
        logic irq;
    } lpm_state_t;

endpackage : lpm_pkg

// *** hw/lpm_top.sv ***
// Purpose: far-end line and pointer justification performance counters
// Assumes: event inputs come from same-clock framer logic, one cycle each
// Notes: counters run free and wrap; software clears them all at once
`include "lpm_defs.svh"
`timescale 1ns/100ps

module lpm_top #(
    parameter int unsigned SEC_CYCLES = `LPM_SEC_CYCLES
)
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_reset_n,
    // pointer justification events
    input wire logic i_pos_just_det,
    input wire logic i_neg_just_det,
    input wire logic i_pos_just_gen,
    input wire logic i_neg_just_gen,
    // far-end line indications
    input wire logic i_rei_valid,
    input wire logic [7:0] i_rei_errs,
    input wire logic i_rdi_defect,
    input wire logic i_rfi_failure,
    // register port
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    // interrupt
    output logic o_irq
);

    ////////////////////////////////////////////////////////////////////////
    // functions

    function automatic logic [31:0] bump(input logic [31:0] v, input logic en);
        bump = en ? v + 32'h0000_0001 : v;
    endfunction : bump

    function automatic logic [7:0] clamp(input logic [7:0] v, input logic [7:0] lim);
        clamp = (v > lim) ? lim : v;
    endfunction : clamp

    ////////////////////////////////////////////////////////////////////////
    // state

    localparam logic [26:0] SEC_LAST = 27'(SEC_CYCLES - 1);

    lpm_pkg::lpm_state_t s_r;
    lpm_pkg::lpm_state_t s_nxt;

    logic tick;
    logic clr_now;
    logic [7:0] rei_lim;
    logic [7:0] rei_inc;
    logic [31:0] sec_errs;
    logic sec_rdi;
    logic sec_es;
    logic sec_ses;
    logic fail_start;
    logic [5:0] rd_idx;

    // one-second boundary on the last cycle of each interval
    assign tick = (s_r.sec_cnt == SEC_LAST);
    assign clr_now = i_wr && (i_addr == `LPM_A_CTRL) && i_wdata[`LPM_CTRL_CLR];

    // a report beyond the legal range is a corrupt byte, so cap it
    assign rei_lim = s_r.oc48 ? `LPM_REI_MAX_OC48 : `LPM_REI_MAX_LOW;
    assign rei_inc = i_rei_valid ? clamp(i_rei_errs, rei_lim) : 8'h00;

    // this cycle's report still belongs to the closing second
    assign sec_errs = s_r.cv_cur + {24'h00_0000, rei_inc};
    assign sec_rdi = s_r.rdi_seen | i_rdi_defect;
    assign sec_es = (sec_errs != 32'h0000_0000) || sec_rdi;
    assign sec_ses = (sec_errs >= {16'h0000, s_r.k}) || sec_rdi;

    // counted at its start, so a later boundary can never count it again
    assign fail_start = i_rfi_failure && !s_r.rfi_d;

    assign rd_idx = i_addr[7:2] - 6'(`LPM_A_CNT0 >> 2);

    ////////////////////////////////////////////////////////////////////////
    // next state

    always_comb
    begin
        s_nxt = s_r;
        s_nxt.sec_cnt = tick ? 27'h0 : s_r.sec_cnt + 27'h1;
        s_nxt.rfi_d = i_rfi_failure;

        // justification counters only run while monitoring is enabled
        s_nxt.cnt[`LPM_CNT_PD] = bump(s_r.cnt[`LPM_CNT_PD],
                                      s_r.pj_en && i_pos_just_det);
        s_nxt.cnt[`LPM_CNT_ND] = bump(s_r.cnt[`LPM_CNT_ND],
                                      s_r.pj_en && i_neg_just_det);
        s_nxt.cnt[`LPM_CNT_PG] = bump(s_r.cnt[`LPM_CNT_PG],
                                      s_r.pj_en && i_pos_just_gen);
        s_nxt.cnt[`LPM_CNT_NG] = bump(s_r.cnt[`LPM_CNT_NG],
                                      s_r.pj_en && i_neg_just_gen);

        s_nxt.cnt[`LPM_CNT_CV] = s_r.cnt[`LPM_CNT_CV] + {24'h00_0000, rei_inc};
        s_nxt.cnt[`LPM_CNT_FC] = bump(s_r.cnt[`LPM_CNT_FC], fail_start);

        if (tick)
        begin
            s_nxt.cv_cur = 32'h0000_0000;
            s_nxt.rdi_seen = 1'b0;
            s_nxt.cnt[`LPM_CNT_ES] = bump(s_r.cnt[`LPM_CNT_ES], sec_es);
            s_nxt.cnt[`LPM_CNT_SES] = bump(s_r.cnt[`LPM_CNT_SES], sec_ses);
            unique case (s_r.avail)
                lpm_pkg::LPM_AVAIL:
                begin
                    if (!sec_ses)
                        s_nxt.run = 4'h0;
                    else if (s_r.run + 4'h1 == `LPM_UNAV_RUN)
                    begin
                        s_nxt.avail = lpm_pkg::LPM_UNAVAIL;
                        s_nxt.run = 4'h0;
                    end
                    else
                        s_nxt.run = s_r.run + 4'h1;
                end
                lpm_pkg::LPM_UNAVAIL:
                begin
                    if (sec_ses)
                        s_nxt.run = 4'h0;
                    else if (s_r.run + 4'h1 == `LPM_UNAV_RUN)
                    begin
                        s_nxt.avail = lpm_pkg::LPM_AVAIL;
                        s_nxt.run = 4'h0;
                    end
                    else
                        s_nxt.run = s_r.run + 4'h1;
                end
            endcase
            // no retroactive adjustment: a second counts once the state is held
            s_nxt.cnt[`LPM_CNT_UAS] = bump(s_r.cnt[`LPM_CNT_UAS],
                                           s_nxt.avail == lpm_pkg::LPM_UNAVAIL);
        end
        else
        begin
            s_nxt.cv_cur = sec_errs;
            s_nxt.rdi_seen = sec_rdi;
        end

        // register writes
        if (i_wr)
        begin
            unique case (i_addr)
                `LPM_A_CTRL:
                begin
                    s_nxt.pj_en = i_wdata[`LPM_CTRL_PJ_EN];
                    s_nxt.oc48 = i_wdata[`LPM_CTRL_OC48];
                end
                `LPM_A_K:
                    s_nxt.k = i_wdata[15:0];
                `LPM_A_MASK:
                    s_nxt.mask = i_wdata[`LPM_N_EV-1:0];
                default:
                    s_nxt.k = s_nxt.k;
            endcase
        end

        if (clr_now)
        begin
            s_nxt.cnt = '0;
        end

        // sticky events; a set in the cycle of its clear wins
        s_nxt.stat = s_r.stat;
        if (i_wr && (i_addr == `LPM_A_STAT))
            s_nxt.stat = s_r.stat & ~i_wdata[`LPM_N_EV-1:0];
        s_nxt.stat[`LPM_EV_SEC] = s_nxt.stat[`LPM_EV_SEC] | tick;
        s_nxt.stat[`LPM_EV_SES] = s_nxt.stat[`LPM_EV_SES] | (tick && sec_ses);
        s_nxt.stat[`LPM_EV_AVAIL] = s_nxt.stat[`LPM_EV_AVAIL] | (s_nxt.avail != s_r.avail);
        s_nxt.stat[`LPM_EV_FAIL] = s_nxt.stat[`LPM_EV_FAIL] | fail_start;
        s_nxt.irq = |(s_nxt.stat & s_nxt.mask);

        // read data stands only in the cycle after the strobe
        s_nxt.rdata = 32'h0000_0000;
        if (i_rd)
        begin
            unique case (i_addr)
                `LPM_A_CTRL:
                    s_nxt.rdata = {30'h0, s_r.oc48, s_r.pj_en};
                `LPM_A_K:
                    s_nxt.rdata = {16'h0000, s_r.k};
                `LPM_A_STAT:
                    s_nxt.rdata = {28'h000_0000, s_r.stat};
                `LPM_A_MASK:
                    s_nxt.rdata = {28'h000_0000, s_r.mask};
                `LPM_A_LIVE:
                    s_nxt.rdata = {29'h0, s_r.rfi_d, s_r.rdi_seen,
                                   s_r.avail == lpm_pkg::LPM_UNAVAIL};
                default:
                begin
                    if (i_addr[1:0] == 2'b00 && i_addr >= `LPM_A_CNT0
                        && i_addr < `LPM_A_LIVE)
                    begin
                        // blank justification counts while monitoring is off; other counts still read
                        if (rd_idx >= 6'(`LPM_N_PJ) || s_r.pj_en)
                            s_nxt.rdata = s_r.cnt[rd_idx[3:0]];
                    end
                end
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            s_r <= '0;
            s_r.k <= `LPM_K_RST;
            s_r.avail <= lpm_pkg::LPM_AVAIL;
        end
        else
            s_r <= s_nxt;
    end

    assign o_rdata = s_r.rdata;
    assign o_irq = s_r.irq;

    ////////////////////////////////////////////////////////////////////////
    // assertions

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);

    pdet_count_a: assert property (
        i_pos_just_det && s_r.pj_en && !clr_now
        |=> s_r.cnt[`LPM_CNT_PD] == $past(s_r.cnt[`LPM_CNT_PD]) + 32'h1)
        else $error("detected positive justification not counted");

    ndet_count_a: assert property (
        i_neg_just_det && s_r.pj_en && !clr_now
        |=> s_r.cnt[`LPM_CNT_ND] == $past(s_r.cnt[`LPM_CNT_ND]) + 32'h1)
        else $error("detected negative justification not counted");

    pgen_count_a: assert property (
        i_pos_just_gen && s_r.pj_en && !clr_now
        |=> s_r.cnt[`LPM_CNT_PG] == $past(s_r.cnt[`LPM_CNT_PG]) + 32'h1)
        else $error("generated positive justification not counted");

    ngen_count_a: assert property (
        i_neg_just_gen && s_r.pj_en && !clr_now
        |=> s_r.cnt[`LPM_CNT_NG] == $past(s_r.cnt[`LPM_CNT_NG]) + 32'h1)
        else $error("generated negative justification not counted");

    pj_blank_a: assert property (
        i_rd && !s_r.pj_en && i_addr >= `LPM_A_CNT0 && i_addr < 8'h20
        |=> o_rdata == 32'h0)
        else $error("justification count visible while disabled");

    cv_add_a: assert property (
        !tick && !clr_now
        |=> s_r.cv_cur == $past(s_r.cv_cur) + {24'h0, $past(rei_inc)})
        else $error("far-end errors not added to current second");

    rei_range_a: assert property (
        i_rei_valid && !s_r.oc48 && i_rei_errs > `LPM_REI_MAX_LOW
        |-> rei_inc == `LPM_REI_MAX_LOW)
        else $error("far-end report not limited to 8 x N");

    es_rdi_a: assert property (
        tick && i_rdi_defect && !clr_now
        |=> s_r.cnt[`LPM_CNT_ES] == $past(s_r.cnt[`LPM_CNT_ES]) + 32'h1)
        else $error("second with RDI-L not errored");

    ses_k_a: assert property (
        tick && !clr_now && sec_errs >= {16'h0, s_r.k}
        |=> s_r.cnt[`LPM_CNT_SES] == $past(s_r.cnt[`LPM_CNT_SES]) + 32'h1
            && s_r.stat[`LPM_EV_SES])
        else $error("second reaching K not severe");

    unav_enter_a: assert property (
        tick && sec_ses && s_r.avail == lpm_pkg::LPM_AVAIL && s_r.run == 4'h9
        |=> s_r.avail == lpm_pkg::LPM_UNAVAIL)
        else $error("tenth severe second did not declare unavailability");

    unav_exit_a: assert property (
        tick && !sec_ses && s_r.avail == lpm_pkg::LPM_UNAVAIL && s_r.run == 4'h9
        |=> s_r.avail == lpm_pkg::LPM_AVAIL)
        else $error("tenth clean second did not clear unavailability");

    fc_start_a: assert property (
        $rose(i_rfi_failure) && !clr_now
        |=> s_r.cnt[`LPM_CNT_FC] == $past(s_r.cnt[`LPM_CNT_FC]) + 32'h1)
        else $error("failure event not counted at its start");

    fc_span_a: assert property (
        i_rfi_failure && s_r.rfi_d && !clr_now
        |=> $stable(s_r.cnt[`LPM_CNT_FC]))
        else $error("ongoing failure counted again");

    sec_tick_a: assert property (
        tick |=> s_r.sec_cnt == 27'h0 && s_r.stat[`LPM_EV_SEC])
        else $error("interval counter did not restart at boundary");

    cv_total_a: assert property (
        !clr_now
        |=> s_r.cnt[`LPM_CNT_CV] == $past(s_r.cnt[`LPM_CNT_CV]) + {24'h0, $past(rei_inc)})
        else $error("far-end errors not added to the running total");

    rei_oc48_a: assert property (
        i_rei_valid && s_r.oc48
        |-> rei_inc == i_rei_errs)
        else $error("far-end report cut below 255 at the high rate");

    es_count_a: assert property (
        tick && !clr_now && sec_errs != 32'h0
        |=> s_r.cnt[`LPM_CNT_ES] == $past(s_r.cnt[`LPM_CNT_ES]) + 32'h1)
        else $error("second with reported errors not errored");

    es_clean_a: assert property (
        tick && !clr_now && sec_errs == 32'h0 && !sec_rdi
        |=> $stable(s_r.cnt[`LPM_CNT_ES]))
        else $error("clean second counted as errored");

    ses_rdi_a: assert property (
        tick && i_rdi_defect && !clr_now
        |=> s_r.cnt[`LPM_CNT_SES] == $past(s_r.cnt[`LPM_CNT_SES]) + 32'h1)
        else $error("second with RDI-L not severe");

    ses_below_a: assert property (
        tick && !clr_now && sec_errs < {16'h0, s_r.k} && !sec_rdi
        |=> $stable(s_r.cnt[`LPM_CNT_SES]))
        else $error("second below K counted as severe");

    uas_count_a: assert property (
        tick && !clr_now && sec_ses && s_r.avail == lpm_pkg::LPM_UNAVAIL
        |=> s_r.cnt[`LPM_CNT_UAS] == $past(s_r.cnt[`LPM_CNT_UAS]) + 32'h1)
        else $error("unavailable second not counted");

    uas_avail_a: assert property (
        tick && !clr_now && !sec_ses && s_r.avail == lpm_pkg::LPM_AVAIL
        |=> $stable(s_r.cnt[`LPM_CNT_UAS]))
        else $error("available second counted as unavailable");

    fc_idle_a: assert property (
        !i_rfi_failure && !clr_now
        |=> $stable(s_r.cnt[`LPM_CNT_FC]))
        else $error("failure counted without RFI-L");

endmodule : lpm_top

// *** tb/lpm_far_end.sv ***
// Purpose: far-end line terminating equipment model
// Assumes: the bench calls the tasks; levels hold until changed
// Notes: idle report lines carry the inverse of the last report
`timescale 1ns/100ps

module lpm_far_end
(
    // clock
    input wire logic i_clk,
    // line indications toward the block
    output logic o_rei_valid,
    output logic [7:0] o_rei_errs,
    output logic o_rdi_defect,
    output logic o_rfi_failure
);
    initial
    begin
        o_rei_valid = 1'b0;
        o_rei_errs = 8'h00;
        o_rdi_defect = 1'b0;
        o_rfi_failure = 1'b0;
    end

    // one frame report; a count above the rate limit is sent only on request
    task automatic report(input logic [7:0] errs);
        @(posedge i_clk);
        o_rei_valid <= 1'b1;
        o_rei_errs <= errs;
        @(posedge i_clk);
        o_rei_valid <= 1'b0;
        o_rei_errs <= ~errs;
    endtask : report

    task automatic set_levels(input logic rdi, input logic rfi);
        @(posedge i_clk);
        o_rdi_defect <= rdi;
        o_rfi_failure <= rfi;
    endtask : set_levels
endmodule : lpm_far_end

// *** tb/tb_top.sv ***
// Purpose: self-checking bench for the far-end line counters
// Assumes: short seconds of SEC cycles; mask bit0 paces the bench
// Notes: every wait is bounded
`include "lpm_defs.svh"
`timescale 1ns/100ps

module tb_top;
    localparam int unsigned SEC = 20;
    logic i_clk = 1'b0;
    logic i_reset_n = 1'b0;
    logic [3:0] ev = 4'h0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [31:0] rdata;
    logic irq;
    logic rei_valid;
    logic [7:0] rei_errs;
    logic rdi;
    logic rfi;
    logic [31:0] v;
    int bad_count = 0;
    int samples_checked = 0;

    always #4 i_clk = ~i_clk;

    lpm_far_end i_far (.i_clk(i_clk), .o_rei_valid(rei_valid), .o_rei_errs(rei_errs),
        .o_rdi_defect(rdi), .o_rfi_failure(rfi));

    lpm_top #(.SEC_CYCLES(SEC)) i_dut (.i_clk(i_clk), .i_reset_n(i_reset_n),
        .i_pos_just_det(ev[0]), .i_neg_just_det(ev[1]), .i_pos_just_gen(ev[2]),
        .i_neg_just_gen(ev[3]), .i_rei_valid(rei_valid), .i_rei_errs(rei_errs),
        .i_rdi_defect(rdi), .i_rfi_failure(rfi), .i_addr(addr), .i_wdata(wdata),
        .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_irq(irq));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : conclude

    task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            bad_count++;
            $display("Error: %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge i_clk);
        wr <= 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge i_clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge i_clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask : rd_reg

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string name);
        rd_reg(a, v);
        chk(name, v, exp);
    endtask : rd_chk

    function automatic logic [7:0] ca(input int i);
        return 8'(`LPM_A_CNT0 + 4 * i);
    endfunction : ca

    task automatic pulse(input logic [3:0] m, input int n);
        @(posedge i_clk);
        ev <= m;
        repeat (n) @(posedge i_clk);
        ev <= 4'h0;
    endtask : pulse

    // wait for the second tick, then clear all status bits
    task automatic sync();
        int n;
        n = 0;
        // step off the edge so irq is never read in the step that launches it
        #1;
        while (irq !== 1'b1 && n < 3 * SEC)
        begin
            @(posedge i_clk);
            #1;
            n++;
        end
        if (irq !== 1'b1)
        begin
            bad_count++;
            $display("Error: second tick expected 1 seen %b", irq);
            conclude();
        end
        else
        begin
            wr_reg(`LPM_A_STAT, 32'h0000000F);
            repeat (2) @(posedge i_clk);
            #1;
        end
    endtask : sync

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (4) @(posedge i_clk);
        i_reset_n <= 1'b1;
        rd_chk(`LPM_A_CTRL, 32'h0, "ctrl reset");
        rd_chk(`LPM_A_K, {16'h0, `LPM_K_RST}, "k reset");
        chk("irq reset", {31'h0, irq}, 32'h0);
        pulse(4'hF, 3);
        for (int i = 0; i < 4; i++)
            rd_chk(ca(i), 32'h0, "hidden just count");
        wr_reg(`LPM_A_CTRL, 32'h1);
        for (int i = 0; i < 4; i++)
            pulse(4'h1 << i, i + 1);
        pulse(4'hF, 2);
        wr_reg(ca(0), 32'hFF);
        for (int i = 0; i < 4; i++)
            rd_chk(ca(i), 32'(i + 3), "just count");
        rd_chk(8'h40, 32'h0, "unmapped");
        // monitoring off: nonzero counts read blank and keep their values
        wr_reg(`LPM_A_CTRL, 32'h0);
        pulse(4'hF, 1);
        for (int i = 0; i < 4; i++)
            rd_chk(ca(i), 32'h0, "just count off");
        wr_reg(`LPM_A_CTRL, 32'h1);
        for (int i = 0; i < 4; i++)
            rd_chk(ca(i), 32'(i + 3), "just count kept");
        // over-range reports are clamped by rate
        wr_reg(`LPM_A_CTRL, 32'h5);
        i_far.report(8'hC8);
        rd_chk(ca(`LPM_CNT_CV), 32'(`LPM_REI_MAX_LOW), "cv low rate");
        wr_reg(`LPM_A_CTRL, 32'h3);
        i_far.report(8'hC8);
        rd_chk(ca(`LPM_CNT_CV), 32'(`LPM_REI_MAX_LOW) + 32'hC8, "cv oc48");
        // errored and severe seconds with K at 3
        wr_reg(`LPM_A_K, 32'h3);
        wr_reg(`LPM_A_MASK, 32'h1);
        // the first call only drops stale status; the second aligns to a tick
        repeat (2) sync();
        wr_reg(`LPM_A_CTRL, 32'h5);
        i_far.report(8'h02);
        sync();
        i_far.report(8'h01);
        i_far.report(8'h02);
        sync();
        i_far.set_levels(1'b1, 1'b0);
        i_far.set_levels(1'b0, 1'b0);
        sync();
        rd_chk(ca(`LPM_CNT_ES), 32'h3, "errored seconds");
        rd_chk(ca(`LPM_CNT_SES), 32'h2, "severe seconds");
        // unavailability entry and exit
        wr_reg(`LPM_A_CTRL, 32'h5);
        // a clean second first, so the two severe seconds above start no run
        sync();
        i_far.set_levels(1'b1, 1'b0);
        repeat (9) sync();
        rd_reg(`LPM_A_LIVE, v);
        chk("unavail after 9", v & 32'h1, 32'h0);
        rd_chk(ca(`LPM_CNT_UAS), 32'h0, "uas after 9");
        sync();
        i_far.set_levels(1'b0, 1'b0);
        rd_reg(`LPM_A_LIVE, v);
        chk("unavail after 10", v & 32'h1, 32'h1);
        rd_chk(ca(`LPM_CNT_UAS), 32'h1, "uas after 10");
        repeat (10) sync();
        rd_reg(`LPM_A_LIVE, v);
        chk("unavail 9 clean", v & 32'h1, 32'h1);
        rd_chk(ca(`LPM_CNT_UAS), 32'hB, "uas 9 clean");
        sync();
        rd_reg(`LPM_A_LIVE, v);
        chk("unavail 10 clean", v & 32'h1, 32'h0);
        rd_chk(ca(`LPM_CNT_UAS), 32'hB, "uas 10 clean");
        // a failure spanning two boundaries counts once
        wr_reg(`LPM_A_CTRL, 32'h5);
        i_far.set_levels(1'b0, 1'b1);
        repeat (2) sync();
        i_far.set_levels(1'b0, 1'b0);
        rd_chk(ca(`LPM_CNT_FC), 32'h1, "failure count");
        i_far.set_levels(1'b0, 1'b1);
        i_far.set_levels(1'b0, 1'b0);
        rd_chk(ca(`LPM_CNT_FC), 32'h2, "failure count 2");
        rd_reg(`LPM_A_STAT, v);
        chk("failure status", v & 32'h8, 32'h8);
        // masked tick leaves the interrupt low but the status set
        sync();
        wr_reg(`LPM_A_MASK, 32'h0);
        repeat (SEC) @(posedge i_clk);
        #1;
        chk("irq masked", {31'h0, irq}, 32'h0);
        rd_reg(`LPM_A_STAT, v);
        chk("tick status", v & 32'h1, 32'h1);
        conclude();
    end
endmodule : tb_top
